// ===== odc_pkg.sv
// Shared constants and types for the octal converter control block.
// Assumes nothing of its surroundings; the interface, engine and top files import it.
`default_nettype none

package odc_pkg;

  // ----------------------------------------------------------------------
  // Sizes of the channel bank and of a serial frame.
  // ----------------------------------------------------------------------
  localparam int CHAN_N = 8;
  localparam int DATA_W = 16;
  localparam int FRAME_W = 24;
  localparam int CHAN_W = 3;
  localparam int PD_W = 16;
  localparam int MASK_W = 8;

  // ----------------------------------------------------------------------
  // Frame field positions: command, channel select, data.
  // ----------------------------------------------------------------------
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int SEL_MSB = 19;
  localparam int SEL_LSB = 16;
  localparam int SEL_MULTI_BIT = 3;

  // Upper five bits of the 7-bit bus address; two straps fill the rest.
  localparam logic [4:0] BUS_ADDR_HI = 5'h03;

  // Command codes carried in the top nibble of a frame.
  localparam logic [3:0] CMD_WR_INPUT = 4'h1;
  localparam logic [3:0] CMD_UPDATE = 4'h2;
  localparam logic [3:0] CMD_WR_UPDATE = 4'h3;
  localparam logic [3:0] CMD_PWRDN = 4'h4;
  localparam logic [3:0] CMD_MASK = 4'h5;

  // Per-channel power-down field: high bit, low bit and its codes.
  localparam int PWRDN_MODE_HI = 1;
  localparam int PWRDN_MODE_LO = 0;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_GND_1K = 2'h1;
  localparam logic [1:0] PD_HIZ = 2'h3;

  // Reset values of the stored control state.
  localparam logic [PD_W-1:0] PD_RST = 16'h0000;
  localparam logic [MASK_W-1:0] MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] CODE_RST = 16'h0000;

  // Bit counter value of the acknowledge clock and of a byte's last bit.
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Phase of the serial engine within a transaction.
  typedef enum logic [1:0] {
    LNK_ADDR,
    LNK_WRITE,
    LNK_READ,
    LNK_SKIP
  } odc_link_e;

  typedef logic [CHAN_N-1:0][DATA_W-1:0] odc_bank_t;

endpackage

`default_nettype wire

// ===== odc_link_if.sv
// Carrier between the serial-clock engine and the core register bank.
// Assumes words are held stable long before the far side samples them.
`timescale 1ns/1ps
`default_nettype none

interface odc_link_if;
  import odc_pkg::*;
  logic [FRAME_W-1:0] frame;     // Write bytes as shifted in; a whole 24-bit frame at each toggle.
  logic frame_tgl;               // Toggles once per complete frame.
  logic [CHAN_W-1:0] rd_ptr;     // Channel whose input register is read.
  logic [DATA_W-1:0] rd_word;    // Input register of that channel.
  logic [6:0] dev_addr;          // Bus address this device answers.
  logic core_rst_n;              // Core reset; the pointer outlives starts.

  modport link (output frame, output frame_tgl, output rd_ptr,
                input rd_word, input dev_addr, input core_rst_n);
  modport core (input frame, input frame_tgl, input rd_ptr,
                output rd_word, output dev_addr, output core_rst_n);
endinterface

`default_nettype wire

// ===== odc_sync.sv
// Two-stage synchroniser for a group of slow levels.
// Assumes each bit is a level; multi-bit groups must be quasi-static.
`timescale 1ns/1ps
`default_nettype none

module odc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // First stage, read only by the second stage.
  logic [W-1:0] sync_q; // Second stage, safe for logic.

  // Both stages clear under reset and then simply shift.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

`default_nettype wire

// ===== odc_i2c_link.sv
// Serial engine on the bus clock: address match, write bytes, readback.
// Assumes its reset is held from stop until the first low after a start.
`timescale 1ns/1ps
`default_nettype none

module odc_i2c_link (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sda_i,
  output logic sda_oe,
  odc_link_if.link lnk
);
  import odc_pkg::*;

  odc_link_e st_q, st_d;            // Transaction phase.
  logic [3:0] cnt_q, cnt_d;         // Bit within the 9-clock byte slot.
  logic [7:0] sh_q, sh_d;           // Incoming byte shifter.
  logic [1:0] idx_q, idx_d;         // Write bytes taken so far.
  logic [FRAME_W-1:0] frame_q, frame_d;
  logic tgl_q, tgl_d;
  logic [CHAN_W-1:0] ptr_q, ptr_d;  // Readback channel pointer.
  logic ack_q, ack_d;               // We acknowledge the current slot.
  logic half_q, half_d;             // Low data byte is next when set.
  logic oe_q, oe_d;
  logic [7:0] byte_v;
  logic rd_bit;

  // ----------------------------------------------------------------------
  // Rising edge: sample the data line and advance the byte protocol.
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    idx_d = idx_q;
    frame_d = frame_q;
    tgl_d = tgl_q;
    ptr_d = ptr_q;
    ack_d = ack_q;
    half_d = half_q;
    byte_v = {sh_q[6:0], sda_i};
    if (cnt_q != ACK_SLOT) begin
      cnt_d = cnt_q + 4'h1;
      sh_d = byte_v;
      if (cnt_q == LAST_BIT) begin
        ack_d = 1'b0;
        case (st_q)
          LNK_ADDR: begin
            if (byte_v[7:1] == lnk.dev_addr) begin
              ack_d = 1'b1;
              idx_d = 2'h0;
              half_d = 1'b0;
              st_d = byte_v[0] ? LNK_READ : LNK_WRITE;
            end else begin
              st_d = LNK_SKIP;
            end
          end
          LNK_WRITE: begin
            // Bytes past the third are refused with a not-acknowledge.
            if (idx_q != 2'h3) begin
              ack_d = 1'b1;
              idx_d = idx_q + 2'h1;
              frame_d = {frame_q[FRAME_W-9:0], byte_v};
              if (idx_q == 2'h0) begin
                // Pointer restarts from each command byte.
                ptr_d = byte_v[SEL_MULTI_BIT] ? '0 : byte_v[2:0];
              end
              if (idx_q == 2'h2) begin
                tgl_d = ~tgl_q;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end else begin
      cnt_d = 4'h0;
      ack_d = 1'b0;
      // The master answers our data bytes; our own address ack is skipped.
      if (st_q == LNK_READ && !ack_q) begin
        if (sda_i) begin
          st_d = LNK_SKIP;
        end else begin
          half_d = ~half_q;
          if (half_q) begin
            ptr_d = ptr_q + 3'h1;
          end
        end
      end
    end
  end

  // Registers of the rising-edge side.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= LNK_ADDR;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      idx_q <= 2'h0;
      frame_q <= '0;
      tgl_q <= 1'b0;
      ack_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      idx_q <= idx_d;
      frame_q <= frame_d;
      tgl_q <= tgl_d;
      ack_q <= ack_d;
      half_q <= half_d;
    end
  end

  // The pointer runs on the core reset, not the engine's: a repeated start
  // resets the engine, yet must keep the channel of the command byte.
  always_ff @(posedge clk or negedge lnk.core_rst_n) begin
    if (!lnk.core_rst_n) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // ----------------------------------------------------------------------
  // Falling edge: the line changes only as the clock falls and holds while it is high.
  // ----------------------------------------------------------------------
  // High byte first; the word settled during the previous clock high.
  assign rd_bit = lnk.rd_word[{~half_q, ~cnt_q[2:0]}];
  always_comb begin
    oe_d = (cnt_q == ACK_SLOT) && ack_q;
    if (st_q == LNK_READ && cnt_q != ACK_SLOT) begin
      oe_d = ~rd_bit;
    end
  end

  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign sda_oe = oe_q;
  assign lnk.frame = frame_q;
  assign lnk.frame_tgl = tgl_q;
  assign lnk.rd_ptr = ptr_q;

  // ----------------------------------------------------------------------
  // Checks on the bus clock.
  // ----------------------------------------------------------------------
  chk_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == LNK_READ && cnt_q == ACK_SLOT && !ack_q && !sda_i && half_q
    |=> ptr_q == (($past(ptr_q) == 3'h7) ? 3'h0 : $past(ptr_q) + 3'h1))
    else $error("readback pointer did not step or wrap");
  chk_ack_drive: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q == ACK_SLOT && ack_q |-> sda_oe)
    else $error("accepted byte not acknowledged");
  cov_read_wrap: cover property (@(posedge clk) disable iff (!rst_n)
    st_q == LNK_READ && ptr_q == 3'h7 ##1 ptr_q == 3'h0);
endmodule

`default_nettype wire

// ===== odc_top.sv
// Control logic of an eight-channel 16-bit converter behind a 2-wire bus.
// Assumes open-drain data pad outside; the bus clock is a clock port.
`timescale 1ns/1ps
`default_nettype none

module odc_top (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic load_strobe_n,
  input wire logic [1:0] addr_strap,
  output logic [odc_pkg::CHAN_N-1:0][odc_pkg::DATA_W-1:0] dac_code,
  output logic [odc_pkg::PD_W-1:0] pwrdn_mode
);
  import odc_pkg::*;

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers.
  // ----------------------------------------------------------------------
  logic rst_s1_q; // First reset stage.
  logic rst_n;    // Released copy of the reset used everywhere else.
  logic [5:0] pin_s; // Synced {frame toggle, scl, sda, strobe, straps}.
  logic tgl_s, scl_s, sda_s, load_strobe_n_s;
  logic [1:0] strap_s;
  logic [CHAN_W-1:0] ptr_s; // Readback pointer seen by this domain.

  // Reset asserts at once and releases two clocks after the pin does.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  odc_link_if lnk ();

  // Pins and the frame toggle share one synchroniser bank.
  odc_sync #(.W(6)) u_pin_sync (
    .clk(clock),
    .rst_n(rst_n),
    .d({lnk.frame_tgl, scl_clk, sda_i, load_strobe_n, addr_strap}),
    .q(pin_s)
  );
  assign {tgl_s, scl_s, sda_s, load_strobe_n_s, strap_s} = pin_s;

  // The pointer only moves at a rising bus clock edge, well ahead of use.
  odc_sync #(.W(CHAN_W)) u_ptr_sync (
    .clk(clock),
    .rst_n(rst_n),
    .d(lnk.rd_ptr),
    .q(ptr_s)
  );

  // ----------------------------------------------------------------------
  // Start and stop detection; they frame the bus-clock engine's reset.
  // ----------------------------------------------------------------------
  logic scl_p_q, sda_p_q, tgl_p_q, load_strobe_n_p_q; // Previous synced levels.
  logic idle_q, idle_d;   // Between a stop and the next start.
  logic pend_q, pend_d;   // Start seen, clock not yet low.
  logic link_rst_n_q, link_rst_n_d;
  logic start_c, stop_c, frame_evt, load_strobe_n_fall;

  assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign frame_evt = tgl_s ^ tgl_p_q;
  assign load_strobe_n_fall = load_strobe_n_p_q && !load_strobe_n_s;

  // The engine cannot see a stop, since its clock stops with the bus;
  // holding it in reset here ends every frame cleanly instead.
  always_comb begin
    idle_d = idle_q;
    pend_d = pend_q;
    if (stop_c) begin
      idle_d = 1'b1;
    end
    if (start_c) begin
      idle_d = 1'b0;
      pend_d = 1'b1;
    end else if (!scl_s) begin
      pend_d = 1'b0;
    end
    link_rst_n_d = !(idle_d || pend_d);
  end

  // Edge history and framing state.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
      tgl_p_q <= 1'b0;
      load_strobe_n_p_q <= 1'b0;
      idle_q <= 1'b1;
      pend_q <= 1'b0;
      link_rst_n_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      tgl_p_q <= tgl_s;
      load_strobe_n_p_q <= load_strobe_n_s;
      idle_q <= idle_d;
      pend_q <= pend_d;
      link_rst_n_q <= link_rst_n_d;
    end
  end

  odc_i2c_link u_link (
    .clk(scl_clk),
    .rst_n(link_rst_n_q),
    .sda_i(sda_i),
    .sda_oe(sda_oe),
    .lnk(lnk.link)
  );

  // ----------------------------------------------------------------------
  // Register bank: input stage, output stage, power-down and mask.
  // ----------------------------------------------------------------------
  odc_bank_t in_q, in_d;     // Input stage per channel.
  odc_bank_t dac_q, dac_d;   // Output stage per channel.
  logic [PD_W-1:0] pd_q, pd_d;
  logic [MASK_W-1:0] mask_q, mask_d;
  logic [DATA_W-1:0] rd_word_q;
  logic [6:0] addr_q;
  logic [3:0] f_cmd, f_sel;
  logic [DATA_W-1:0] f_data;
  logic f_one; // Frame names a single channel.

  assign f_cmd = lnk.frame[CMD_MSB:CMD_LSB];
  assign f_sel = lnk.frame[SEL_MSB:SEL_LSB];
  assign f_data = lnk.frame[DATA_W-1:0];
  assign f_one = !f_sel[SEL_MULTI_BIT];

  // Strobe edges first, then the frame, so a frame in the same cycle
  // lands on top of the copy it raced with.
  always_comb begin
    in_d = in_q;
    dac_d = dac_q;
    pd_d = pd_q;
    mask_d = mask_q;
    for (int ch = 0; ch < CHAN_N; ch++) begin
      if (load_strobe_n_fall && !mask_q[ch]) begin
        dac_d[ch] = in_q[ch];
      end
    end
    if (frame_evt) begin
      case (f_cmd)
        CMD_WR_INPUT: begin
          if (f_one) begin
            in_d[f_sel[2:0]] = f_data;
            // A masked channel reads the strobe as high.
            if (!load_strobe_n_s && !mask_q[f_sel[2:0]]) begin
              dac_d[f_sel[2:0]] = f_data;
            end
          end
        end
        CMD_UPDATE: begin
          if (f_one) begin
            dac_d[f_sel[2:0]] = in_q[f_sel[2:0]];
          end
        end
        CMD_WR_UPDATE: begin
          if (f_one) begin
            in_d[f_sel[2:0]] = f_data;
            dac_d[f_sel[2:0]] = f_data;
          end
        end
        // Modes only; codes stay put and keep taking updates.
        CMD_PWRDN: pd_d = f_data;
        CMD_MASK: mask_d = f_data[MASK_W-1:0];
        default: begin
          // Reserved and unsupported codes change nothing.
        end
      endcase
    end
  end

  // Bank registers, readback word and the captured straps.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_q <= {CHAN_N{CODE_RST}};
      dac_q <= {CHAN_N{CODE_RST}};
      pd_q <= PD_RST;
      mask_q <= MASK_RST;
      rd_word_q <= CODE_RST;
      addr_q <= 7'h00;
    end else begin
      in_q <= in_d;
      dac_q <= dac_d;
      pd_q <= pd_d;
      mask_q <= mask_d;
      rd_word_q <= in_q[ptr_s];
      addr_q <= {BUS_ADDR_HI, strap_s};
    end
  end

  // The pad only ever pulls low, so its output level is a constant flop.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  assign lnk.rd_word = rd_word_q;
  assign lnk.dev_addr = addr_q;
  // The engine's pointer keeps this reset across starts and stops.
  assign lnk.core_rst_n = rst_n;
  assign dac_code = dac_q;
  assign pwrdn_mode = pd_q;

  // ----------------------------------------------------------------------
  // Checks on the core clock.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_mask_reset: assert property ($rose(rst_n) |-> mask_q == 8'h00)
    else $error("strobe mask not clear after reset");
  chk_strobe_copy: assert property (load_strobe_n_fall && !mask_q[0] && !frame_evt
    |=> dac_q[0] == $past(in_q[0]))
    else $error("strobe edge did not copy channel 0");
  chk_mask_block: assert property (load_strobe_n_fall && mask_q[0] && !frame_evt
    |=> $stable(dac_q[0]))
    else $error("masked channel followed the strobe");
  chk_write_high: assert property (frame_evt && f_cmd == 4'h1 && load_strobe_n_s
    |=> $stable(dac_q))
    else $error("write-input with strobe high moved output");
  chk_write_low: assert property (frame_evt && f_cmd == 4'h1 && f_one
    && !load_strobe_n_s && !mask_q[f_sel[2:0]]
    |=> dac_q[$past(f_sel[2:0])] == $past(f_data)
        && in_q[$past(f_sel[2:0])] == $past(f_data))
    else $error("write-input with strobe low missed a stage");
  chk_update_cmd: assert property (frame_evt && f_cmd == 4'h2 && f_one
    |=> dac_q[$past(f_sel[2:0])] == $past(in_q[f_sel[2:0]]))
    else $error("update command did not copy input stage");
  chk_pwrdn_keep: assert property (frame_evt && f_cmd == 4'h4 && !load_strobe_n_fall
    |=> pwrdn_mode == $past(f_data) && $stable(dac_q))
    else $error("power-down load wrong or output codes touched");
  chk_mask_load: assert property (frame_evt && f_cmd == 4'h5
    |=> mask_q == $past(f_data[7:0]) && $stable(in_q))
    else $error("mask command stored wrong bits");
  chk_reserved_cmd: assert property (frame_evt && f_cmd[3] && !load_strobe_n_fall
    |=> $stable(in_q) && $stable(dac_q) && $stable(pd_q) && $stable(mask_q))
    else $error("reserved command changed state");
  // Each effect lands one edge after its cause; a check that spans a
  // strobe edge and a frame in the same cycle leaves that case out.
  chk_read_word: assert property ($stable(ptr_s) && $stable(in_q)
    |-> rd_word_q == in_q[ptr_s])
    else $error("readback word not the input stage");
  chk_wr_update: assert property (frame_evt && f_cmd == 4'h3 && f_one
    |=> dac_q[$past(f_sel[2:0])] == $past(f_data)
        && in_q[$past(f_sel[2:0])] == $past(f_data))
    else $error("write-update command missed a stage");
  chk_multi_skip: assert property (frame_evt && f_cmd == 4'h1 && !f_one
    && !load_strobe_n_fall |=> $stable(in_q) && $stable(dac_q))
    else $error("channel code above seven changed a channel");
  chk_pd_reset: assert property ($rose(rst_n) |-> pd_q == 16'h0000
    && dac_q == '0)
    else $error("power-down modes or codes not clear after reset");
  chk_strobe_last: assert property (load_strobe_n_fall && !mask_q[7] && !frame_evt
    |=> dac_q[7] == $past(in_q[7]))
    else $error("strobe edge did not copy channel 7");
  chk_addr_fixed: assert property (rst_n
    |=> addr_q == {5'h03, $past(strap_s)})
    else $error("bus address not fixed bits plus straps");
  chk_stop_reset: assert property (stop_c |-> ##[1:2] !link_rst_n_q)
    else $error("stop did not park the bus engine");

  cov_strobe_edge: cover property (load_strobe_n_fall && mask_q != 8'h00);
  cov_pwrdn_frame: cover property (frame_evt && f_cmd == 4'h4);
  cov_write_low: cover property (frame_evt && f_cmd == 4'h1 && !load_strobe_n_s);
  cov_mask_frame: cover property (frame_evt && f_cmd == 4'h5);
endmodule

`default_nettype wire

// ===== odc_i2c_master.sv
// Bus master model on the 2-wire port of the converter control block.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module odc_i2c_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // --------------------------------------------------------------
  // Idle bus: clock stands high, data released.
  // --------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start or repeated start; the odd lead-in skews phase to the core.
  task automatic start();
    #7;
    sda_low = 1'b0;
    #20 scl = 1'b1;
    #20 sda_low = 1'b1;
    #20 scl = 1'b0;
    #20;
  endtask

  // Stop: data rises while the clock is high, then the clock rests.
  task automatic stop();
    sda_low = 1'b1;
    #20 scl = 1'b1;
    #20 sda_low = 1'b0;
    #40;
  endtask

  // One pulse: drive in the low phase, sample mid high phase.
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
    #20;
  endtask

  // Eight bits MSB first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule

`default_nettype wire

// ===== odc_top_bench.sv
// Self-checking bench of the converter control block.
// Assumes the master model owns the bus clock; no checker of its own.
`timescale 1ns/1ps
`default_nettype none

module odc_top_bench;
  import odc_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic load_strobe_n = 1'b1;
  logic [1:0] addr_strap = 2'h2;
  logic scl, sda_low, sda_oe, sda_o, sda;
  logic [CHAN_N-1:0][DATA_W-1:0] dac_code;
  logic [PD_W-1:0] pwrdn_mode;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [15:0] rnd = 16'h0044;
  logic [15:0] in_m [CHAN_N];
  logic [15:0] dac_m [CHAN_N];
  logic [7:0] mask_m = 8'h00;
  logic [15:0] pd_m = 16'h0000;

  // Open-drain wire with pull-up.
  assign sda = !(sda_oe || sda_low);
  always #2 clock = ~clock;

  odc_top u_odc_top (.clock(clock), .reset_n(reset_n), .scl_clk(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .load_strobe_n(load_strobe_n), .addr_strap(addr_strap),
    .dac_code(dac_code), .pwrdn_mode(pwrdn_mode));
  odc_i2c_master u_odc_i2c_master (.scl(scl), .sda_low(sda_low),
    .sda(sda));

  // --------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic end_of_test();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic cmp_all();
    for (int c = 0; c < CHAN_N; c++) begin
      chk("dac_code", dac_code[c], dac_m[c]);
    end
    chk("pwrdn_mode", pwrdn_mode, pd_m);
    chk("sda_o", {15'h0, sda_o}, 16'h0000);
  endtask

  // Sends a byte; a low acknowledge from the device is expected if ok.
  task automatic send(input logic [7:0] b, input logic ok);
    logic [7:0] rx;
    logic ack;
    u_odc_i2c_master.xfer(b, 1'b1, rx, ack);
    chk("ack", {15'h0, ack}, {15'h0, !ok});
  endtask

  // Whole write frame, then the expected state is advanced and compared.
  task automatic frame(input logic [3:0] cmd, input logic [3:0] sel,
                       input logic [15:0] d);
    logic [2:0] ch;
    ch = sel[2:0];
    u_odc_i2c_master.start();
    send({BUS_ADDR_HI, addr_strap, 1'b0}, 1'b1);
    send({cmd, sel}, 1'b1);
    send(d[15:8], 1'b1);
    send(d[7:0], 1'b1);
    u_odc_i2c_master.stop();
    wait_clk(12);
    case (cmd)
      CMD_WR_INPUT: if (!sel[3]) begin
        in_m[ch] = d;
        if (!load_strobe_n && !mask_m[ch]) dac_m[ch] = d;
      end
      CMD_UPDATE: if (!sel[3]) dac_m[ch] = in_m[ch];
      CMD_WR_UPDATE: if (!sel[3]) begin
        in_m[ch] = d;
        dac_m[ch] = d;
      end
      CMD_PWRDN: pd_m = d;
      CMD_MASK: mask_m = d[7:0];
      default: ;
    endcase
    cmp_all();
  endtask

  // Command byte sets the pointer, repeated start, n words read.
  task automatic rdback(input logic [3:0] sel, input int n);
    logic [7:0] hi, lo;
    logic ack;
    int p;
    p = sel[3] ? 0 : sel[2:0];
    u_odc_i2c_master.start();
    send({BUS_ADDR_HI, addr_strap, 1'b0}, 1'b1);
    send({4'h0, sel}, 1'b1);
    u_odc_i2c_master.start();
    send({BUS_ADDR_HI, addr_strap, 1'b1}, 1'b1);
    for (int k = 0; k < n; k++) begin
      u_odc_i2c_master.xfer(8'hff, 1'b0, hi, ack);
      u_odc_i2c_master.xfer(8'hff, k == n - 1, lo, ack);
      chk("readback", {hi, lo}, in_m[p]);
      p = (p + 1) % CHAN_N;
    end
    u_odc_i2c_master.stop();
    wait_clk(12);
  endtask

  // Strobe pulse: unmasked channels copy input to output stage.
  task automatic strobe();
    @(posedge clock);
    load_strobe_n <= 1'b0;
    wait_clk(12);
    for (int c = 0; c < CHAN_N; c++) begin
      if (!mask_m[c]) dac_m[c] = in_m[c];
    end
    cmp_all();
    load_strobe_n <= 1'b1;
    wait_clk(12);
  endtask

  // Hang guard.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  // --------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------
  initial begin
    for (int c = 0; c < CHAN_N; c++) begin
      in_m[c] = 16'h0000;
      dac_m[c] = 16'h0000;
    end
    wait_clk(10);
    reset_n <= 1'b1;
    wait_clk(20);
    cmp_all();
    u_odc_i2c_master.start();
    send({BUS_ADDR_HI, ~addr_strap, 1'b0}, 1'b0);
    u_odc_i2c_master.stop();
    for (int c = 0; c < CHAN_N; c++) begin
      rnd = lfsr(rnd);
      frame(CMD_WR_INPUT, c[3:0], rnd);
    end
    rdback(4'h5, 10);
    rdback(4'h9, 2);
    strobe();
    @(posedge clock);
    load_strobe_n <= 1'b0;
    rnd = lfsr(rnd);
    frame(CMD_WR_INPUT, 4'h2, rnd);
    frame(CMD_MASK, 4'hc, 16'hffa5);
    rnd = lfsr(rnd);
    frame(CMD_WR_INPUT, 4'h0, rnd);
    @(posedge clock);
    load_strobe_n <= 1'b1;
    for (int c = 0; c < CHAN_N; c++) begin
      rnd = lfsr(rnd);
      frame(CMD_WR_INPUT, c[3:0], rnd);
    end
    strobe();
    frame(CMD_UPDATE, 4'h2, 16'h0000);
    rnd = lfsr(rnd);
    frame(CMD_WR_UPDATE, 4'h7, rnd);
    frame(CMD_PWRDN, 4'h0, 16'hc1d4);
    rnd = lfsr(rnd);
    frame(CMD_WR_UPDATE, 4'h4, rnd);
    frame(4'h0, 4'h3, rnd);
    frame(4'h9, 4'h3, rnd);
    frame(CMD_WR_INPUT, 4'h9, rnd);
    rdback(4'h0, 8);
    end_of_test();
  end
endmodule

`default_nettype wire
